// File: rtl/host_port_map.vh
// constants for the host access port of the network controller
`ifndef HOST_PORT_MAP_VH
`define HOST_PORT_MAP_VH

// =====================================================================
// interface select strap codes {if_select_hi, if_select_lo}
`define MODE_SEP_NOLATCH 2'h0
`define MODE_SEP_LATCH 2'h1
`define MODE_MUXED 2'h2
`define MODE_SERIAL 2'h3

// =====================================================================
// synchroniser idle value, msb first:
// cs_n, sel_hi, sel_lo, write_n, read_n, ale, ser_in, sclk, reset_n,
// addr[7:0], bus[7:0]
// idle: deselected, straps 00, strobes high, latch low, reset released
`define SYNC_WIDTH 25
`define SYNC_IDLE 25'h131_0000

// =====================================================================
// interrupt pulse length in oscillator periods
`define INT_PULSE_OSC 32
`define INT_CNT_W 6

// =====================================================================
// serial framing
`define BIT_LAST 3'h7
`define BIT_FIRST 3'h0
`define ADDR_STEP 8'h01
`define BYTE_ZERO 8'h00

`endif

// File: rtl/ser_byte_shifter.v
// serial byte shifter: lsb-first receive on sclk rise, send on sclk fall
`timescale 1ns/100ps
`default_nettype none
`include "host_port_map.vh"

module ser_byte_shifter (
  input wire mclk,
  input wire sys_rst,
  input wire srst,
  input wire active,
  input wire sclk_s,
  input wire ser_in_s,
  input wire load,
  input wire [7:0] load_data,
  output reg [7:0] rx_byte,
  output reg byte_done,
  output reg ser_out_bit
);

  reg sclk_d;
  reg [2:0] bit_cnt;
  reg [7:0] rx_sr;
  reg [7:0] tx_sr;
  wire rise;
  wire fall;

  assign rise = active & sclk_s & ~sclk_d;
  assign fall = active & ~sclk_s & sclk_d;

  // =====================================================================
  // shift engine
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      sclk_d <= 1'b0;
      bit_cnt <= `BIT_FIRST;
      rx_sr <= `BYTE_ZERO;
      tx_sr <= `BYTE_ZERO;
      rx_byte <= `BYTE_ZERO;
      byte_done <= 1'b0;
      ser_out_bit <= 1'b0;
    end else if (srst) begin
      sclk_d <= 1'b0;
      bit_cnt <= `BIT_FIRST;
      rx_sr <= `BYTE_ZERO;
      tx_sr <= `BYTE_ZERO;
      rx_byte <= `BYTE_ZERO;
      byte_done <= 1'b0;
      ser_out_bit <= 1'b0;
    end else begin
      sclk_d <= sclk_s;
      byte_done <= 1'b0;
      if (!active) begin
        bit_cnt <= `BIT_FIRST;
      end else if (rise) begin
        rx_sr <= {ser_in_s, rx_sr[7:1]}; // R8 R9
        bit_cnt <= bit_cnt + 3'h1;
        if (bit_cnt == `BIT_LAST) begin
          rx_byte <= {ser_in_s, rx_sr[7:1]};
          byte_done <= 1'b1;
        end
      end else if (fall) begin
        ser_out_bit <= tx_sr[bit_cnt]; // R9 R11
      end
      if (load) begin
        tx_sr <= load_data;
        ser_out_bit <= load_data[0];
      end
    end
  end

endmodule // ser_byte_shifter

`default_nettype wire

// File: rtl/can_ctrl_host_interface.v
// host access port: parallel or serial host bus to internal memory port
`timescale 1ns/100ps
`default_nettype none
`include "host_port_map.vh"

// Contract
// R1: host pins act only while chip select is low and are ignored otherwise.
// R2: two strap inputs pick separate, latched separate, muxed or serial bus.
// R3: with the latch mode in use the address is captured while the latch is high.
// R4: in parallel mode write data is taken while the write strobe is low.
// R5: in parallel mode read data drives the data pins only while read is low.
// R6: muxed mode takes address then data on shared pins, separate uses addr pins.
// R7: the host holds unused address pins steady and data pins low in serial mode.
// R8: a serial transfer is an address byte then data bytes, each lsb first.
// R9: serial input is sampled on shift clock rise, output changes on its fall.
// R10: direction high shifts read data out, low floats output and writes data.
// R11: serial output floats with chip select high and sends lsb first when low.
// R12: ready/wait shows a pending access, low in parallel and high in serial.
// R13: an interrupt drives the interrupt output low for 32 oscillator periods.
// R14: transmit, receive and error events share the one interrupt output.
// R15: the whole port is held in reset while the reset pin is low.
// R16: the host waits for ready/wait to show completion before moving on.
module can_ctrl_host_interface #(
  parameter INT_CYCLES = `INT_PULSE_OSC
) (
  input wire mclk,
  input wire sys_rst,
  input wire reset_n,
  input wire cs_n,
  input wire if_select_hi,
  input wire if_select_lo,
  input wire [7:0] host_addr_in,
  input wire [7:0] host_data_in,
  output reg [7:0] host_data_out,
  output reg host_data_oe,
  input wire par_write_n,
  input wire par_read_n,
  input wire addr_latch_strobe,
  input wire serial_in,
  input wire shift_clk,
  output wire serial_out,
  output reg serial_out_oe,
  output wire ready_wait,
  output reg int_n,
  input wire ev_tx_done,
  input wire ev_rx_done,
  input wire ev_error,
  output reg mem_req,
  output reg mem_we,
  output reg [7:0] mem_addr,
  output reg [7:0] mem_wdata,
  input wire [7:0] mem_rdata,
  input wire mem_ack
);

  localparam [31:0] INT_LOAD_FULL = INT_CYCLES - 1;
  localparam [`INT_CNT_W-1:0] INT_LOAD = INT_LOAD_FULL[`INT_CNT_W-1:0];

  // =====================================================================
  // pin synchronisers
  reg [`SYNC_WIDTH-1:0] sync1;
  reg [`SYNC_WIDTH-1:0] sync2;

  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      sync1 <= `SYNC_IDLE;
      sync2 <= `SYNC_IDLE;
    end else begin
      sync1 <= {cs_n, if_select_hi, if_select_lo, par_write_n, par_read_n,
                addr_latch_strobe, serial_in, shift_clk, reset_n,
                host_addr_in, host_data_in};
      sync2 <= sync1;
    end
  end

  wire cs_n_s = sync2[24];
  wire [1:0] mode_s = sync2[23:22];
  wire wr_n_s = sync2[21];
  wire rd_n_s = sync2[20];
  wire ale_s = sync2[19];
  wire ser_in_s = sync2[18];
  wire sclk_s = sync2[17];
  wire rst_n_s = sync2[16];
  wire [7:0] addr_s = sync2[15:8];
  wire [7:0] bus_s = sync2[7:0];

  wire srst = ~rst_n_s; // R15
  wire cs_act = ~cs_n_s; // R1
  wire ser_mode = (mode_s == `MODE_SERIAL); // R2
  wire par_mode = ~ser_mode;
  wire ser_direction = rd_n_s;

  // =====================================================================
  // parallel strobes and address capture
  reg wr_d;
  reg rd_d;
  reg [7:0] addr_latched;
  wire wr_fall = cs_act & par_mode & wr_d & ~wr_n_s;
  wire rd_fall = cs_act & par_mode & rd_d & ~rd_n_s;
  wire [7:0] par_addr = (mode_s == `MODE_SEP_NOLATCH) ? addr_s
                        : addr_latched; // R6

  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_d <= 1'b1;
      rd_d <= 1'b1;
      addr_latched <= `BYTE_ZERO;
    end else if (srst) begin
      wr_d <= 1'b1;
      rd_d <= 1'b1;
      addr_latched <= `BYTE_ZERO;
    end else begin
      wr_d <= wr_n_s;
      rd_d <= rd_n_s;
      if (cs_act && ale_s) begin
        if (mode_s == `MODE_SEP_LATCH)
          addr_latched <= addr_s; // R3
        else if (mode_s == `MODE_MUXED)
          addr_latched <= bus_s; // R3 R6
      end
    end
  end

  // =====================================================================
  // serial framing
  wire ser_active = cs_act & ser_mode;
  wire [7:0] rx_byte;
  wire byte_done;
  reg first_byte;
  reg [7:0] ser_addr;
  reg tx_load;
  // read data is only valid in the ack cycle, so hold it for the load
  reg [7:0] tx_data;

  ser_byte_shifter u_shift (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .srst(srst),
    .active(ser_active),
    .sclk_s(sclk_s),
    .ser_in_s(ser_in_s),
    .load(tx_load),
    .load_data(tx_data),
    .rx_byte(rx_byte),
    .byte_done(byte_done),
    .ser_out_bit(serial_out)
  );

  // =====================================================================
  // internal access requests
  wire ser_first = byte_done & first_byte;
  wire ser_data = byte_done & ~first_byte;
  wire issue_rd = ~mem_req & (rd_fall | (ser_first & ser_direction)
                  | (ser_data & ser_direction));
  wire issue_wr = ~mem_req & (wr_fall | (ser_data & ~ser_direction));

  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_addr <= `BYTE_ZERO;
      mem_wdata <= `BYTE_ZERO;
      first_byte <= 1'b1;
      ser_addr <= `BYTE_ZERO;
      tx_load <= 1'b0;
      tx_data <= `BYTE_ZERO;
      host_data_out <= `BYTE_ZERO;
    end else if (srst) begin
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_addr <= `BYTE_ZERO;
      mem_wdata <= `BYTE_ZERO;
      first_byte <= 1'b1;
      ser_addr <= `BYTE_ZERO;
      tx_load <= 1'b0;
      tx_data <= `BYTE_ZERO;
      host_data_out <= `BYTE_ZERO;
    end else begin
      tx_load <= 1'b0;
      if (!ser_active) begin
        first_byte <= 1'b1;
      end else if (ser_first) begin
        first_byte <= 1'b0; // R8
        ser_addr <= ser_direction ? rx_byte + `ADDR_STEP : rx_byte;
      end else if (ser_data) begin
        ser_addr <= ser_addr + `ADDR_STEP;
      end
      if (mem_req && mem_ack) begin
        mem_req <= 1'b0;
        if (!mem_we) begin
          tx_data <= mem_rdata; // R10
          if (ser_mode)
            tx_load <= 1'b1; // R10
          else
            host_data_out <= mem_rdata; // R5
        end
      end else if (issue_wr) begin
        mem_req <= 1'b1;
        mem_we <= 1'b1;
        mem_addr <= ser_mode ? ser_addr : par_addr;
        mem_wdata <= ser_mode ? rx_byte : bus_s; // R4 R10
      end else if (issue_rd) begin
        mem_req <= 1'b1;
        mem_we <= 1'b0;
        mem_addr <= ser_mode ? (ser_first ? rx_byte : ser_addr)
                    : par_addr;
      end
    end
  end

  // =====================================================================
  // pin drivers
  assign ready_wait = ser_mode ? mem_req : ~mem_req; // R12

  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      host_data_oe <= 1'b0;
      serial_out_oe <= 1'b0;
    end else if (srst) begin
      host_data_oe <= 1'b0;
      serial_out_oe <= 1'b0;
    end else begin
      host_data_oe <= cs_act & par_mode & ~rd_n_s; // R5
      serial_out_oe <= ser_active & ser_direction; // R10 R11
    end
  end

  // =====================================================================
  // self-clearing interrupt pulse
  reg [`INT_CNT_W-1:0] int_cnt;
  wire int_event = ev_tx_done | ev_rx_done | ev_error; // R14

  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      int_cnt <= {`INT_CNT_W{1'b0}};
      int_n <= 1'b1;
    end else if (srst) begin
      int_cnt <= {`INT_CNT_W{1'b0}};
      int_n <= 1'b1;
    end else if (int_event) begin
      int_cnt <= INT_LOAD; // R13
      int_n <= 1'b0;
    end else if (int_cnt != {`INT_CNT_W{1'b0}}) begin
      int_cnt <= int_cnt - {{(`INT_CNT_W-1){1'b0}}, 1'b1};
    end else begin
      int_n <= 1'b1; // R13
    end
  end

endmodule // can_ctrl_host_interface

`default_nettype wire

// File: tb/host_port_chk_sva.sv
// assertion checker bound to the host access port
`timescale 1ns/100ps
`default_nettype none
// =====================================================
// checker
module host_port_chk #(parameter INT_CYCLES = 32) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic reset_n,
  input wire logic cs_n,
  input wire logic if_select_hi,
  input wire logic if_select_lo,
  input wire logic par_read_n,
  input wire logic host_data_oe,
  input wire logic serial_out_oe,
  input wire logic ready_wait,
  input wire logic int_n,
  input wire logic ev_tx_done,
  input wire logic ev_rx_done,
  input wire logic ev_error,
  input wire logic mem_req,
  input wire logic [7:0] mem_addr,
  input wire logic mem_ack
);
  logic [6:0] cnt_reg;
  wire logic ev_any = ev_tx_done | ev_rx_done | ev_error;
  wire logic ser = if_select_hi & if_select_lo;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst || !reset_n);
  // low cycles of the interrupt output since its last cause
  always @(posedge mclk or posedge sys_rst)
    if (sys_rst) cnt_reg <= 7'h00;
    else if (ev_any || !reset_n) cnt_reg <= 7'h00;
    else if (!int_n) cnt_reg <= cnt_reg + 7'h01;
  property p_int_go; ev_any |-> ##[1:2] !int_n; endproperty
  a_int_go: assert property (p_int_go) else $error("int not low");
  property p_int_len; $rose(int_n) |-> cnt_reg == INT_CYCLES; endproperty
  a_int_len: assert property (p_int_len) else $error("int length");
  property p_int_max; !int_n |-> cnt_reg < INT_CYCLES; endproperty
  a_int_max: assert property (p_int_max) else $error("int too long");
  property p_rdy_pol; mem_req |-> ready_wait == ser; endproperty
  a_rdy_pol: assert property (p_rdy_pol) else $error("ready level");
  property p_oe_rd;
    host_data_oe |-> !$past(cs_n, 3) && !$past(par_read_n, 3) && !ser;
  endproperty
  a_oe_rd: assert property (p_oe_rd) else $error("data drive");
  property p_sout_cs; cs_n[*6] |-> !serial_out_oe; endproperty
  a_sout_cs: assert property (p_sout_cs) else $error("sout driven");
  property p_req_hold;
    mem_req && !mem_ack |=> mem_req && $stable(mem_addr);
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("req held");
  property p_req_end; mem_req && mem_ack |=> !mem_req; endproperty
  a_req_end: assert property (p_req_end) else $error("req end");
endmodule // host_port_chk
bind can_ctrl_host_interface host_port_chk #(.INT_CYCLES(INT_CYCLES))
  chk_u (.*);
`default_nettype wire

// File: tb/mem_model.sv
// memory side responder for the host access port
`timescale 1ns/100ps
`default_nettype none
// =====================================================
// byte memory answering each request after dly cycles
module mem_model (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [3:0] dly,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [7:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  output var logic [7:0] mem_rdata,
  output var logic mem_ack
);
  logic [7:0] mem [0:255];
  logic [3:0] wait_reg;
  initial for (int i = 0; i < 256; i++) mem[i] = i[7:0] ^ 8'h5a;
  always @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      wait_reg <= 4'h0;
      mem_ack <= 1'b0;
      mem_rdata <= 8'h00;
    end else begin
      mem_ack <= 1'b0;
      // read data is only valid with the ack
      mem_rdata <= ~mem_rdata;
      if (mem_req && !mem_ack) begin
        wait_reg <= wait_reg + 4'h1;
        if (wait_reg == dly) begin
          wait_reg <= 4'h0;
          mem_ack <= 1'b1;
          mem_rdata <= mem[mem_addr];
          if (mem_we) mem[mem_addr] <= mem_wdata;
        end
      end
    end
  end
endmodule // mem_model
`default_nettype wire

// File: tb/can_ctrl_host_interface_tb.sv
// self-checking bench for the host access port
`timescale 1ns/100ps
`default_nettype none
// =====================================================
// bench top
module can_ctrl_host_interface_tb;
  logic mclk = 1'b0, sys_rst = 1'b1, reset_n = 1'b1, cs_n = 1'b1;
  logic if_select_hi = 1'b0, if_select_lo = 1'b0, par_write_n = 1'b1;
  logic par_read_n = 1'b1, addr_latch_strobe = 1'b0, serial_in = 1'b0;
  logic shift_clk = 1'b0, ev_tx_done = 1'b0, ev_rx_done = 1'b0;
  logic ev_error = 1'b0, mem_ack, mem_req, mem_we, host_data_oe;
  logic serial_out, serial_out_oe, ready_wait, int_n;
  logic [7:0] host_addr_in = 8'h00, host_drv = 8'h00, host_data_out;
  logic [7:0] mem_addr, mem_wdata, mem_rdata, q;
  logic [3:0] dly = 4'h2;
  int err_count = 0, checks = 0, cyc = 0;
  wire logic [7:0] host_data_in = host_data_oe ? host_data_out : host_drv;
  can_ctrl_host_interface #(.INT_CYCLES(32)) dut_u (.mclk, .sys_rst,
    .reset_n, .cs_n, .if_select_hi, .if_select_lo, .host_addr_in,
    .host_data_in, .host_data_out, .host_data_oe, .par_write_n,
    .par_read_n, .addr_latch_strobe, .serial_in, .shift_clk, .serial_out,
    .serial_out_oe, .ready_wait, .int_n, .ev_tx_done, .ev_rx_done,
    .ev_error, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_rdata,
    .mem_ack);
  mem_model mem_u (.mclk, .sys_rst, .dly, .mem_req, .mem_we, .mem_addr,
    .mem_wdata, .mem_rdata, .mem_ack);
  always #25 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      end_sim();
    end
  end
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wait_rw(input logic v);
    int n;
    n = 0;
    while (ready_wait !== v && n < 60) begin
      @(negedge mclk);
      n++;
    end
    chk(8'(ready_wait), 8'(v));
  endtask
  task automatic set_mode(input logic [1:0] m);
    {if_select_hi, if_select_lo} = m;
    repeat (6) @(negedge mclk);
  endtask
  task automatic par_cyc(input logic wr, input logic [7:0] a, d);
    cs_n = 1'b0;
    if (if_select_hi | if_select_lo) begin
      addr_latch_strobe = 1'b1;
      if (if_select_hi) host_drv = a;
      else host_addr_in = a;
      repeat (4) @(negedge mclk);
      addr_latch_strobe = 1'b0;
      // a stale address on the pins must not be used
      if (!if_select_hi) host_addr_in = ~a;
      @(negedge mclk);
    end else host_addr_in = a;
    host_drv = d;
    if (wr) par_write_n = 1'b0;
    else par_read_n = 1'b0;
    wait_rw(1'b0);
    wait_rw(1'b1);
    q = host_data_out;
    if (!wr) chk(8'(host_data_oe), 8'h01);
    {par_write_n, par_read_n} = 2'h3;
    repeat (6) @(negedge mclk);
    chk(8'(host_data_oe), 8'h00);
    cs_n = 1'b1;
    repeat (4) @(negedge mclk);
  endtask
  task automatic ser_byte(input logic [7:0] tx, input logic hs);
    for (int i = 0; i < 8; i++) begin
      serial_in = tx[i];
      repeat (4) @(negedge mclk);
      shift_clk = 1'b1;
      repeat (4) @(negedge mclk);
      q[i] = serial_out;
      shift_clk = 1'b0;
    end
    if (hs) wait_rw(1'b1);
    if (hs) wait_rw(1'b0);
    repeat (4) @(negedge mclk);
  endtask
  task automatic t_par;
    for (int m = 0; m < 3; m++) begin
      set_mode(m[1:0]);
      par_cyc(1'b1, 8'h10 + m[7:0], 8'ha0 + m[7:0]);
      par_cyc(1'b0, 8'h10 + m[7:0], 8'h00);
      chk(q, 8'ha0 + m[7:0]);
    end
  endtask
  task automatic t_cs;
    set_mode(2'h0);
    {par_write_n, par_read_n} = 2'h0;
    repeat (10) @(negedge mclk);
    chk(8'(mem_req), 8'h00);
    chk(8'(host_data_oe), 8'h00);
    {par_write_n, par_read_n} = 2'h3;
  endtask
  task automatic t_ser;
    dly = 4'hf;
    host_drv = 8'h00;
    set_mode(2'h3);
    {cs_n, par_write_n, par_read_n} = 3'h0;
    ser_byte(8'h60, 1'b0);
    ser_byte(8'h11, 1'b1);
    ser_byte(8'h22, 1'b1);
    chk(8'(serial_out_oe), 8'h00);
    cs_n = 1'b1;
    repeat (8) @(negedge mclk);
    chk(mem_u.mem[8'h60], 8'h11);
    chk(mem_u.mem[8'h61], 8'h22);
    {cs_n, par_read_n} = 2'h1;
    ser_byte(8'h61, 1'b1);
    ser_byte(8'h00, 1'b1);
    chk(q, 8'h22);
    ser_byte(8'h00, 1'b1);
    chk(q, 8'h38);
    chk(8'(serial_out_oe), 8'h01);
    cs_n = 1'b1;
    repeat (8) @(negedge mclk);
    chk(8'(serial_out_oe), 8'h00);
  endtask
  task automatic t_irq;
    for (int k = 0; k < 4; k++) begin
      {ev_error, ev_rx_done, ev_tx_done} = 3'h1 << (k % 3);
      @(negedge mclk);
      {ev_error, ev_rx_done, ev_tx_done} = 3'h0;
      repeat (3) if (int_n) @(negedge mclk);
      if (k == 3) reset_n = 1'b0;
      q = 8'h00;
      while (int_n === 1'b0 && q < 8'h50) begin
        @(negedge mclk);
        q++;
      end
      if (k < 3) chk(q, 8'h20);
      if (k < 3) chk(8'(int_n), 8'h01);
    end
    repeat (6) @(negedge mclk);
    chk(8'(int_n), 8'h01);
    reset_n = 1'b1;
    repeat (6) @(negedge mclk);
  endtask
  initial begin
    repeat (2) @(negedge mclk);
    sys_rst = 1'b0;
    repeat (4) @(negedge mclk);
    t_par();
    $display("done parallel");
    t_cs();
    $display("done select");
    t_ser();
    $display("done serial");
    t_irq();
    $display("done interrupt");
    end_sim();
  end
endmodule // can_ctrl_host_interface_tb
`default_nettype wire
